// File: rtl/wcg_pkg.sv
// shared constants and state type of the wrap coordinate generator
package wcg_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RANGE = 8'h04;
    localparam logic [7:0] ADDR_RATIO = 8'h08;
    localparam logic [7:0] ADDR_OFFSET = 8'h0c;
    localparam logic [7:0] ADDR_NDIV = 8'h10;
    localparam logic [7:0] ADDR_LEAD = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_MASK = 8'h1c;
    localparam logic [7:0] ADDR_POS = 8'h20;
    localparam logic [7:0] ADDR_APPLY = 8'h24;
    localparam logic [7:0] ADDR_WSTAT = 8'h28;
    // ctrl field positions
    localparam int CTRL_SRC = 0;
    localparam int CTRL_WRAP = 1;
    localparam int CTRL_DIR = 2;
    localparam int CTRL_MECH = 3;
    localparam int CTRL_SPAN = 4;
    // status bits
    localparam int ST_WRAP = 0;
    localparam int ST_DIV = 1;
    localparam int ST_ERR = 2;
    localparam int ST_ALM = 3;
    // reset values
    localparam logic RST_SRC = 1'b0;
    localparam logic RST_WRAP = 1'b1;
    localparam logic RST_DIR = 1'b1;
    localparam logic [15:0] RST_RANGE = 16'h0064;
    localparam logic [13:0] RST_RATIO = 14'h1388;
    localparam logic [29:0] RST_OFFSET = 30'h00000000;
    localparam logic [28:0] RST_NDIV = 29'h00000001;
    localparam logic [14:0] RST_LEAD = 15'h0001;
    localparam logic [7:0] MECH_TYPE = 8'h00;
    // limits and scaling; range is held in tenths of a revolution
    localparam logic [13:0] RATIO_MAX = 14'h2710;
    localparam logic [47:0] RATIO_FULL = 48'h000000002710;
    localparam logic [31:0] STEPS_PER_TENTH = 32'h00000064;
    localparam logic [31:0] SPAN_FULL = 32'h00004650;
    localparam logic [31:0] SPAN_HALF = 32'h00002328;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic src_manual;
        logic wrap_en;
        logic dir_cw;
        logic mech_manual;
        logic span_half;
        logic [15:0] range;
        logic [13:0] ratio;
        logic [29:0] offset;
        logic [28:0] ndiv;
        logic [14:0] lead;
        logic [3:0] status;
        logic [3:0] mask;
        logic load_pend;
        logic c_wrap_en;
        logic c_dir_cw;
        logic c_span_half;
        logic [15:0] c_range;
        logic [13:0] c_ratio;
        logic [29:0] c_offset;
        logic [28:0] c_ndiv;
        logic [31:0] pos;
        logic [31:0] acc;
        logic step_prev;
        logic err_info;
        logic alarm;
        logic wrap_ready;
        logic div_pulse;
    } wcg_state_t;
endpackage : wcg_pkg

// File: rtl/wcg_sync.sv
// two-stage synchronisers for the step pins
module wcg_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] din,
    output logic [1:0] dout
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } wcg_sync_t;

    wcg_sync_t s_r;
    wcg_sync_t s_nxt;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_bit
            always_comb begin
                s_nxt.s1[i] = din[i];
                s_nxt.s2[i] = s_r.s1[i];
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.s2;
endmodule : wcg_sync

// File: rtl/wcg_top.sv
// wrap coordinate generator with apb register file
// Behaviour
// - source select resets to 0 (sensor settings); only 1 loads manual.
// - wrap enable 0 disables and 1 enables wrapping, reset value 1.
// - wrapping returns the position around after the set range, reset 10.
// - offset ratio takes 0 to 10000 in 0.01 percent, reset 5000.
// - offset value is a signed step count, reset 0.
// - direction 0 makes ccw positive, 1 makes cw positive, reset 1.
// - mechanism type is reserved, always reads 0 and changes nothing.
// - lead pitch takes 1 to 32767, reset 1, and steers no motion.
// - wrap operations are permitted only while wrapping is configured.
// - 100 rev with 50 percent and no offset spans -50 to +50 rev.
// - bad range flags error info; reapplying with it set raises alarm.
// - with wrap on, a pulse marks each of n even points from home.
module wcg_top
    import wcg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic step_pulse,
    input wire logic step_cw,
    input wire logic sensor_wrap_en,
    input wire logic sensor_dir_cw,
    input wire logic [15:0] sensor_range,
    input wire logic [13:0] sensor_ratio,
    input wire logic [29:0] sensor_offset,
    input wire logic [28:0] sensor_ndiv,
    output logic [31:0] cmd_position,
    output logic division_boundary_pulse,
    output logic wrap_ready,
    output logic wrap_error,
    output logic wrap_alarm
);
    wcg_state_t s_r;
    wcg_state_t s_nxt;
    logic [1:0] pins;
    logic load_c;
    logic apply_c;
    logic up_c;
    logic step_ev_c;

    wcg_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({step_cw, step_pulse}),
        .dout(pins)
    );

    // geometry of the active coordinate
    logic [31:0] rsteps;
    logic [31:0] rdiv;
    logic [47:0] prod;
    logic [47:0] shift;
    logic [31:0] lower;
    logic [31:0] upper;
    logic [31:0] span;
    logic [31:0] nmod;
    logic range_ok;
    logic home_in;
    logic cfg_err;
    logic active;

    assign rsteps = {16'h0000, s_r.c_range} * STEPS_PER_TENTH;
    assign rdiv = (s_r.c_range == 16'h0000) ? 32'h00000001 : rsteps;
    assign prod = {16'h0000, rsteps} * {34'h0, s_r.c_ratio};
    assign shift = prod / RATIO_FULL;
    assign lower = {{2{s_r.c_offset[29]}}, s_r.c_offset} - shift[31:0];
    assign upper = lower + rsteps - 32'h00000001;
    assign span = s_r.c_span_half ? SPAN_HALF : SPAN_FULL;
    assign range_ok = (s_r.c_range != 16'h0000) &&
        ((span % {16'h0000, s_r.c_range}) == 32'h0);
    assign home_in = ($signed(lower) <= 0) && ($signed(upper) >= 0);
    assign cfg_err = s_r.c_wrap_en && !(range_ok && home_in);
    assign active = s_r.c_wrap_en && !cfg_err && !s_r.alarm;
    assign nmod = {3'h0, s_r.c_ndiv} % rdiv;

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            ADDR_CTRL, ADDR_RANGE, ADDR_RATIO, ADDR_OFFSET, ADDR_NDIV,
            ADDR_LEAD, ADDR_STATUS, ADDR_MASK, ADDR_POS, ADDR_APPLY,
            ADDR_WSTAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    function automatic logic [31:0] rd(input wcg_state_t s,
                                       input logic [7:0] a);
        case (a)
            ADDR_CTRL: rd = {16'h0000, MECH_TYPE, 3'h0, s.span_half,
                s.mech_manual, s.dir_cw, s.wrap_en, s.src_manual};
            ADDR_RANGE: rd = {16'h0000, s.range};
            ADDR_RATIO: rd = {18'h0, s.ratio};
            ADDR_OFFSET: rd = {{2{s.offset[29]}}, s.offset};
            ADDR_NDIV: rd = {3'h0, s.ndiv};
            ADDR_LEAD: rd = {17'h0, s.lead};
            ADDR_STATUS: rd = {28'h0, s.status};
            ADDR_MASK: rd = {28'h0, s.mask};
            ADDR_POS: rd = s.pos;
            ADDR_WSTAT: rd = {29'h0, s.wrap_ready, s.alarm, s.err_info};
            default: rd = 32'h00000000;
        endcase
    endfunction : rd

    always_comb begin
        logic acc_w;
        logic rd_clr;
        logic wr;
        logic [3:0] ev;
        logic [31:0] t;
        acc_w = psel && penable && s_r.pready;
        wr = acc_w && pwrite && !s_r.pslverr;
        rd_clr = acc_w && !pwrite && (paddr == ADDR_STATUS);
        ev = 4'h0;
        t = 32'h0;
        s_nxt = s_r;
        apply_c = wr && (paddr == ADDR_APPLY) && pwdata[0];
        load_c = s_r.load_pend || apply_c;
        step_ev_c = pins[0] && !s_r.step_prev;
        up_c = (pins[1] == s_r.c_dir_cw);
        s_nxt.step_prev = pins[0];
        // apb: zero wait, answer prepared during setup
        if (psel && !penable) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = !mapped(paddr);
            s_nxt.prdata = rd(s_r, paddr);
        end else begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
        end
        if (wr) begin
            case (paddr)
                ADDR_CTRL: begin
                    s_nxt.src_manual = pwdata[CTRL_SRC];
                    s_nxt.wrap_en = pwdata[CTRL_WRAP];
                    s_nxt.dir_cw = pwdata[CTRL_DIR];
                    s_nxt.mech_manual = pwdata[CTRL_MECH];
                    s_nxt.span_half = pwdata[CTRL_SPAN];
                end
                ADDR_RANGE: s_nxt.range = pwdata[15:0];
                ADDR_RATIO: begin
                    if (pwdata[31:0] <= {18'h0, RATIO_MAX}) begin
                        s_nxt.ratio = pwdata[13:0];
                    end
                end
                ADDR_OFFSET: begin
                    if (pwdata[31:29] == {3{pwdata[29]}}) begin
                        s_nxt.offset = pwdata[29:0];
                    end
                end
                ADDR_NDIV: begin
                    if (pwdata[31:29] == 3'h0 && pwdata[28:0] != 29'h0) begin
                        s_nxt.ndiv = pwdata[28:0];
                    end
                end
                ADDR_LEAD: begin
                    if (pwdata[31:15] == 17'h0 && pwdata[14:0] != 15'h0) begin
                        s_nxt.lead = pwdata[14:0];
                    end
                end
                ADDR_MASK: s_nxt.mask = pwdata[3:0];
                default: begin
                end
            endcase
        end
        // capture of the active settings after reset or on apply
        if (load_c) begin
            s_nxt.load_pend = 1'b0;
            if (s_r.src_manual) begin
                s_nxt.c_wrap_en = s_r.wrap_en;
                s_nxt.c_range = s_r.range;
                s_nxt.c_ratio = s_r.ratio;
                s_nxt.c_offset = s_r.offset;
                s_nxt.c_ndiv = s_r.ndiv;
            end else begin
                s_nxt.c_wrap_en = sensor_wrap_en;
                s_nxt.c_range = sensor_range;
                s_nxt.c_ratio = sensor_ratio;
                s_nxt.c_offset = sensor_offset;
                s_nxt.c_ndiv = sensor_ndiv;
            end
            s_nxt.c_dir_cw = s_r.mech_manual ? s_r.dir_cw : sensor_dir_cw;
            s_nxt.c_span_half = s_r.span_half;
            s_nxt.pos = 32'h0;
            s_nxt.acc = 32'h0;
        end else if (step_ev_c) begin
            if (up_c) begin
                if (active && s_r.pos == upper) begin
                    s_nxt.pos = lower;
                    ev[ST_WRAP] = 1'b1;
                end else begin
                    s_nxt.pos = s_r.pos + 32'h1;
                end
                t = s_r.acc + nmod;
                if (t >= rsteps) begin
                    t = t - rsteps;
                end
                ev[ST_DIV] = active && (t < nmod || nmod == 32'h0);
            end else begin
                if (active && s_r.pos == lower) begin
                    s_nxt.pos = upper;
                    ev[ST_WRAP] = 1'b1;
                end else begin
                    s_nxt.pos = s_r.pos - 32'h1;
                end
                if (s_r.acc >= nmod) begin
                    t = s_r.acc - nmod;
                end else begin
                    t = s_r.acc + rsteps - nmod;
                end
                ev[ST_DIV] = active && (nmod == 32'h0 ||
                    (s_r.acc <= nmod && s_r.acc != 32'h0));
            end
            s_nxt.acc = t;
        end
        s_nxt.err_info = cfg_err && !load_c;
        ev[ST_ERR] = cfg_err && !s_r.err_info && !load_c;
        if (apply_c && s_r.err_info) begin
            s_nxt.alarm = 1'b1;
            ev[ST_ALM] = !s_r.alarm;
        end
        s_nxt.div_pulse = ev[ST_DIV];
        s_nxt.wrap_ready = active && !load_c;
        // set wins over the read clear
        s_nxt.status = (rd_clr ? 4'h0 : s_r.status) | ev;
        s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.src_manual <= RST_SRC;
            s_r.wrap_en <= RST_WRAP;
            s_r.dir_cw <= RST_DIR;
            s_r.range <= RST_RANGE;
            s_r.ratio <= RST_RATIO;
            s_r.offset <= RST_OFFSET;
            s_r.ndiv <= RST_NDIV;
            s_r.lead <= RST_LEAD;
            s_r.load_pend <= 1'b1;
            s_r.c_dir_cw <= RST_DIR;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;
    assign cmd_position = s_r.pos;
    assign division_boundary_pulse = s_r.div_pulse;
    assign wrap_ready = s_r.wrap_ready;
    assign wrap_error = s_r.err_info;
    assign wrap_alarm = s_r.alarm;

    // checks
    property p_src_sensor;
        @(posedge pclk) disable iff (!presetn)
        load_c && !s_r.src_manual |=> s_r.c_range == $past(sensor_range);
    endproperty
    a_src_sensor: assert property (p_src_sensor)
        else $error("sensor range not taken with source 0");

    property p_no_wrap_off;
        @(posedge pclk) disable iff (!presetn)
        !active && !load_c && step_ev_c && up_c
        |=> s_r.pos == $past(s_r.pos) + 32'h1 &&
        !$rose(s_r.status[ST_WRAP]);
    endproperty
    a_no_wrap_off: assert property (p_no_wrap_off)
        else $error("position wrapped while wrapping off");

    property p_wrap_top;
        @(posedge pclk) disable iff (!presetn)
        active && !load_c && step_ev_c && up_c && s_r.pos == upper
        |=> s_r.pos == $past(lower) && s_r.status[ST_WRAP];
    endproperty
    a_wrap_top: assert property (p_wrap_top)
        else $error("upper bound did not wrap to lower bound");

    property p_ratio_lim;
        @(posedge pclk) disable iff (!presetn)
        s_r.ratio <= RATIO_MAX && s_r.lead != 15'h0;
    endproperty
    a_ratio_lim: assert property (p_ratio_lim)
        else $error("ratio or lead outside its range");

    property p_mech_zero;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && paddr == ADDR_CTRL |=> prdata[15:8] == 8'h00;
    endproperty
    a_mech_zero: assert property (p_mech_zero)
        else $error("mechanism type read nonzero");

    property p_sym;
        @(posedge pclk) disable iff (!presetn)
        s_r.c_range == 16'h03e8 && s_r.c_ratio == RST_RATIO &&
        s_r.c_offset == 30'h0 |-> lower == 32'hffff3cb0 &&
        upper == 32'h0000c34f;
    endproperty
    a_sym: assert property (p_sym)
        else $error("100 rev at half ratio not symmetric");

    property p_alarm;
        @(posedge pclk) disable iff (!presetn)
        apply_c && s_r.err_info |=> wrap_alarm ##1 wrap_alarm;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("apply with error info gave no alarm");

    property p_div_gate;
        @(posedge pclk) disable iff (!presetn)
        division_boundary_pulse |-> $past(active) && !$past(load_c);
    endproperty
    a_div_gate: assert property (p_div_gate)
        else $error("division pulse while wrapping inactive");

    property p_ready;
        @(posedge pclk) disable iff (!presetn)
        wrap_ready |-> $past(s_r.c_wrap_en) && !wrap_error;
    endproperty
    a_ready: assert property (p_ready)
        else $error("wrap ready without valid wrap setting");

    property p_span;
        @(posedge pclk) disable iff (!presetn)
        upper - lower == rsteps - 32'h1;
    endproperty
    a_span: assert property (p_span)
        else $error("span differs from range");

    property p_apb;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb)
        else $error("apb answer not one cycle after setup");

    c_wrap: cover property (@(posedge pclk) s_r.status[ST_WRAP]);
    c_div: cover property (@(posedge pclk) division_boundary_pulse);
    c_alarm: cover property (@(posedge pclk) wrap_alarm);
    c_read: cover property (@(posedge pclk) pready && !pwrite);
endmodule : wcg_top

// File: verif/wcg_motor.sv
// stepping motor and absolute sensor model for the wrap generator bench
module wcg_motor (
    input wire logic pclk,
    output logic step_pulse,
    output logic step_cw,
    output logic sensor_wrap_en,
    output logic sensor_dir_cw,
    output logic [15:0] sensor_range,
    output logic [13:0] sensor_ratio,
    output logic [29:0] sensor_offset,
    output logic [28:0] sensor_ndiv
);
    timeunit 1ns;
    timeprecision 1ns;
    // stored settings: 0.5 rev range, half offset, two divisions
    assign sensor_wrap_en = 1'b1;
    assign sensor_dir_cw = 1'b1;
    assign sensor_range = 16'h0005;
    assign sensor_ratio = 14'h1388;
    assign sensor_offset = 30'h00000000;
    assign sensor_ndiv = 29'h00000002;
    initial begin
        step_pulse = 1'b0;
        step_cw = 1'b0;
    end
    // direction settles three cycles before each rising step edge
    task automatic step(input logic cw, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            step_cw <= cw;
            repeat (3) @(posedge pclk);
            step_pulse <= 1'b1;
            repeat (3) @(posedge pclk);
            step_pulse <= 1'b0;
        end
        repeat (4) @(posedge pclk);
    endtask : step
endmodule : wcg_motor

// File: verif/tb.sv
// self-checking testbench for the wrap coordinate generator
module tb
    import wcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SR = 500;
    localparam int SLO = -SR * 5000 / 10000;
    localparam int MR = 100000;
    localparam int MLO = 49990 - MR * 5000 / 10000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic step_pulse;
    logic step_cw;
    logic sensor_wrap_en;
    logic sensor_dir_cw;
    logic [15:0] sensor_range;
    logic [13:0] sensor_ratio;
    logic [29:0] sensor_offset;
    logic [28:0] sensor_ndiv;
    logic [31:0] cmd_position;
    logic division_boundary_pulse;
    logic wrap_ready;
    logic wrap_error;
    logic wrap_alarm;
    logic [31:0] rd;
    logic er;
    int n_errors = 0;
    int n_checks = 0;
    int n_div = 0;
    int d0;
    logic [7:0] ra [7] = '{ADDR_CTRL, ADDR_RANGE, ADDR_RATIO, ADDR_OFFSET,
        ADDR_NDIV, ADDR_LEAD, ADDR_MASK};
    logic [31:0] rv [7] = '{32'h6, 32'h64, 32'h1388, 32'h0, 32'h1, 32'h1,
        32'h0};

    always #10 pclk = ~pclk;

    always @(posedge pclk)
        if (division_boundary_pulse === 1'b1)
            n_div <= n_div + 1;

    wcg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .step_pulse(step_pulse), .step_cw(step_cw),
        .sensor_wrap_en(sensor_wrap_en), .sensor_dir_cw(sensor_dir_cw),
        .sensor_range(sensor_range), .sensor_ratio(sensor_ratio),
        .sensor_offset(sensor_offset), .sensor_ndiv(sensor_ndiv),
        .cmd_position(cmd_position),
        .division_boundary_pulse(division_boundary_pulse),
        .wrap_ready(wrap_ready), .wrap_error(wrap_error),
        .wrap_alarm(wrap_alarm));

    wcg_motor u_motor (.pclk(pclk), .step_pulse(step_pulse),
        .step_cw(step_cw), .sensor_wrap_en(sensor_wrap_en),
        .sensor_dir_cw(sensor_dir_cw), .sensor_range(sensor_range),
        .sensor_ratio(sensor_ratio), .sensor_offset(sensor_offset),
        .sensor_ndiv(sensor_ndiv));

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; pready, read data and error taken at one edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (pready !== 1'b1) begin
            n_errors++;
            print_verdict();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task automatic apply;
        wr(ADDR_APPLY, 32'h1);
        repeat (3) @(posedge pclk);
    endtask : apply

    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(wrap_ready, 32'h1);
        chk(wrap_error, 32'h0);
        for (int i = 0; i < 7; i++)
            rdc(ra[i], rv[i]);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        wr(ADDR_RATIO, 32'h2711);
        rdc(ADDR_RATIO, 32'h1388);
        wr(ADDR_RATIO, 32'h2710);
        rdc(ADDR_RATIO, 32'h2710);
        wr(ADDR_LEAD, 32'h0);
        rdc(ADDR_LEAD, 32'h1);
        wr(ADDR_LEAD, 32'h7fff);
        rdc(ADDR_LEAD, 32'h7fff);
        wr(ADDR_OFFSET, 32'h20000000);
        rdc(ADDR_OFFSET, 32'h0);
        wr(ADDR_OFFSET, 32'h1fffffff);
        rdc(ADDR_OFFSET, 32'h1fffffff);
        wr(ADDR_NDIV, 32'h0);
        rdc(ADDR_NDIV, 32'h1);
        wr(ADDR_CTRL, 32'hff06);
        rdc(ADDR_CTRL, 32'h6);
        // sensor settings active: range 500 steps from -250
        wr(ADDR_MASK, 32'h3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        d0 = n_div;
        u_motor.step(1'b1, SR / 2 - 1);
        chk(cmd_position, 32'(SR / 2 - 1));
        chk(32'(n_div - d0), 32'h0);
        chk(irq, 32'h0);
        u_motor.step(1'b1, 1);
        chk(cmd_position, 32'(SLO));
        chk(32'(n_div - d0), 32'h1);
        chk(irq, 32'h1);
        rdc(ADDR_STATUS, 32'h3);
        settle();
        chk(irq, 32'h0);
        wr(ADDR_MASK, 32'h0);
        u_motor.step(1'b1, SR / 2);
        chk(cmd_position, 32'h0);
        chk(32'(n_div - d0), 32'h2);
        chk(irq, 32'h0);
        wr(ADDR_MASK, 32'h3);
        settle();
        chk(irq, 32'h1);
        rdc(ADDR_STATUS, 32'h2);
        // manual 100.0 rev, half ratio, boundary moved next to home
        wr(ADDR_RANGE, 32'h3e8);
        wr(ADDR_RATIO, 32'h1388);
        wr(ADDR_OFFSET, 32'h0);
        wr(ADDR_CTRL, 32'h7);
        apply();
        chk(wrap_error, 32'h0);
        wr(ADDR_OFFSET, 32'hc346);
        apply();
        chk(cmd_position, 32'h0);
        chk(wrap_error, 32'h0);
        u_motor.step(1'b0, 10);
        chk(cmd_position, 32'(MLO));
        u_motor.step(1'b0, 1);
        chk(cmd_position, 32'(MLO + MR - 1));
        wr(ADDR_CTRL, 32'hf);
        wr(ADDR_CTRL, 32'hb);
        apply();
        u_motor.step(1'b0, 1);
        chk(cmd_position, 32'h1);
        wr(ADDR_RANGE, 32'h5);
        wr(ADDR_RATIO, 32'h0);
        wr(ADDR_OFFSET, 32'h0);
        wr(ADDR_CTRL, 32'h9);
        apply();
        chk(wrap_ready, 32'h0);
        u_motor.step(1'b1, 1);
        chk(cmd_position, 32'hffffffff);
        u_motor.step(1'b0, 1);
        chk(cmd_position, 32'h0);
        wr(ADDR_CTRL, 32'hb);
        apply();
        u_motor.step(1'b1, 1);
        chk(cmd_position, 32'(SR - 1));
        // home outside the span, then reapply while flagged
        wr(ADDR_RATIO, 32'h2710);
        apply();
        chk(wrap_error, 32'h1);
        chk(wrap_ready, 32'h0);
        chk(wrap_alarm, 32'h0);
        apply();
        chk(wrap_alarm, 32'h1);
        rdc(ADDR_WSTAT, 32'h3);
        wr(ADDR_RATIO, 32'h0);
        wr(ADDR_RANGE, 32'h7);
        apply();
        chk(wrap_error, 32'h1);
        // 1.6 rev divides the full span but not the half span
        wr(ADDR_RANGE, 32'h10);
        wr(ADDR_CTRL, 32'h1b);
        apply();
        chk(wrap_error, 32'h1);
        wr(ADDR_CTRL, 32'hb);
        apply();
        chk(wrap_error, 32'h0);
        print_verdict();
    end
endmodule : tb
